//--- verilog/tclr_pkg.sv
// Package with constants and types of the colour line realigner
package tclr_pkg;
  // Register map, byte addresses on the Wishbone bus
  localparam logic [3:0] TCLR_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] TCLR_ADDR_STATUS = 4'h4;
  localparam logic [3:0] TCLR_ADDR_COUNT  = 4'h8;
  // Control register fields
  localparam int         TCLR_SET_LSB     = 0;
  localparam int         TCLR_SET_W       = 5;
  localparam logic [4:0] TCLR_SET_RESET   = 5'h00;
  // Setting range limits
  localparam int         TCLR_SET_MAX     = 15;
  // Status register fields
  localparam int         TCLR_ST_VALID    = 0;
  localparam int         TCLR_ST_BLUE     = 1;
  localparam int         TCLR_ST_BYPASS   = 2;
  localparam int         TCLR_ST_RANGE    = 3;
  // Realignment modes
  typedef enum logic [1:0] {TCLR_BYPASS, TCLR_RED_FIRST, TCLR_BLUE_FIRST} tclr_mode_t;
endpackage

//--- verilog/tclr_line_ram.sv
// Simple dual-port memory holding buffered colour samples
`timescale 1ns/1ps
module tclr_line_ram
  import tclr_pkg::*;
#(
  parameter int WIDTH = 24,
  parameter int DEPTH = 1024
)(
  input  wire logic                     clk_i,
  input  wire logic                     we_i,
  input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input  wire logic [WIDTH-1:0]         wdata_i,
  input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic      [WIDTH-1:0]         rdata_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Write port
  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Registered read port
  always_ff @(posedge clk_i)
  begin
    rdata_o <= mem[raddr_i];
  end
endmodule

//--- verilog/tclr_realigner.sv
// Colour line realigner for a trilinear line-scan sensor
//
// How it works
// - One trigger captures red, green, blue together
// - Red start: green d ago, blue 2d
// - Signed setting accepted from -15 to +15
// - Setting zero bypasses realignment, lines pass through
// - Negative setting: blue start, delay magnitude
// - Positive setting: red start, delay value
// - Keep the last 2d+1 acquisitions stored
`timescale 1ns/1ps
module tclr_realigner
  import tclr_pkg::*;
#(
  parameter int PIX_W   = 8,
  parameter int LINE_W  = 64,
  parameter int MAX_DLY = TCLR_SET_MAX
)(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // Sensor pixel stream, all three colours of one pixel together
  input  wire logic                 line_start_i,
  input  wire logic                 pix_valid_i,
  input  wire logic [PIX_W-1:0]     pix_red_i,
  input  wire logic [PIX_W-1:0]     pix_green_i,
  input  wire logic [PIX_W-1:0]     pix_blue_i,
  // Realigned RGB output stream
  output logic                      out_valid_o,
  output logic                      out_line_start_o,
  output logic                      out_line_ok_o,
  output logic      [PIX_W-1:0]     out_red_o,
  output logic      [PIX_W-1:0]     out_green_o,
  output logic      [PIX_W-1:0]     out_blue_o
);
  localparam int SLOTS  = 2 * MAX_DLY + 1;
  localparam int SLOT_W = $clog2(SLOTS);
  localparam int COL_W  = $clog2(LINE_W);
  localparam int DEPTH  = SLOTS * LINE_W;
  localparam int ADDR_W = $clog2(DEPTH);
  localparam int CNT_W  = 6;

  if (MAX_DLY < 1 || MAX_DLY > TCLR_SET_MAX || LINE_W < 2)
  begin : g_check
    $error("tclr_realigner: unsupported parameter values");
  end

  // Circular slot arithmetic: slot index a minus b, modulo SLOTS
  function automatic logic [SLOT_W-1:0] slot_back(input logic [SLOT_W-1:0] a, input logic [SLOT_W:0] b);
    logic [SLOT_W+1:0] s;
    s = {2'b00, a} + (SLOT_W+2)'(SLOTS) - {1'b0, b};
    if (s >= (SLOT_W+2)'(SLOTS))
    begin
      s = s - (SLOT_W+2)'(SLOTS);
    end
    return s[SLOT_W-1:0];
  endfunction

  // Memory address of a slot and column
  function automatic logic [ADDR_W-1:0] slot_addr(input logic [SLOT_W-1:0] sl, input logic [COL_W-1:0] col);
    return ADDR_W'(sl * LINE_W) + ADDR_W'(col);
  endfunction

  //--------------------------------------------------------------
  // Register file
  //--------------------------------------------------------------
  logic [TCLR_SET_W-1:0] setting_q;
  logic                  range_err_q;
  logic [CNT_W-1:0]      fill_q;
  logic [15:0]           line_cnt_q;
  logic                  wb_req;
  logic                  wr_in_range;
  logic                  wr_ctrl;
  logic signed [31:0]    wr_val;
  tclr_mode_t            mode;
  logic [SLOT_W:0]       dly;
  logic                  hist_full;
  logic [TCLR_SET_W-1:0] set_mag;

  assign wb_req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl     = wb_req && wb_we_i && wb_adr_i == TCLR_ADDR_CTRL && wb_sel_i[0];
  assign wr_val      = 32'(signed'(wb_dat_i[7:0]));
  // A delay beyond MAX_DLY would reach past the stored history, so it is refused too
  assign wr_in_range = wr_val >= -MAX_DLY && wr_val <= MAX_DLY;
  // Negate at setting width, so the magnitude is never taken from a wider zero-extended copy
  assign set_mag     = -setting_q;

  // Ack one cycle after the request, drop it the next cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_req;
    end
  end

  // Setting register; out-of-range writes are refused and flagged
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      setting_q   <= TCLR_SET_RESET;
      range_err_q <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      if (wr_in_range)
      begin
        setting_q   <= wb_dat_i[TCLR_SET_LSB +: TCLR_SET_W];
        range_err_q <= 1'b0;
      end
      else
      begin
        range_err_q <= 1'b1;
      end
    end
  end

  // Read mux, unmapped addresses read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= '0;
    end
    else if (wb_req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        TCLR_ADDR_CTRL:   wb_dat_o <= 32'(signed'(setting_q));
        TCLR_ADDR_STATUS: wb_dat_o <= {28'h0000000, range_err_q, mode == TCLR_BYPASS,
                                       mode == TCLR_BLUE_FIRST, hist_full};
        TCLR_ADDR_COUNT:  wb_dat_o <= {16'h0000, line_cnt_q};
        default:          wb_dat_o <= '0;
      endcase
    end
  end

  //--------------------------------------------------------------
  // Mode decode
  //--------------------------------------------------------------
  // Sign picks starting colour, magnitude the delay
  always_comb
  begin
    if (setting_q == '0)
    begin
      mode = TCLR_BYPASS;
      dly  = '0;
    end
    else if (setting_q[TCLR_SET_W-1])
    begin
      mode = TCLR_BLUE_FIRST;
      dly  = (SLOT_W+1)'(set_mag);
    end
    else
    begin
      mode = TCLR_RED_FIRST;
      dly  = (SLOT_W+1)'(setting_q);
    end
  end

  //--------------------------------------------------------------
  // Acquisition history
  //--------------------------------------------------------------
  logic [SLOT_W-1:0]  wslot_q;
  logic [COL_W-1:0]   col_q;
  logic               started_q;
  logic [SLOT_W-1:0]  cur_slot;
  logic [COL_W-1:0]   cur_col;

  assign cur_col  = line_start_i ? '0 : col_q;
  assign cur_slot = (line_start_i && started_q) ? ((wslot_q == SLOT_W'(SLOTS - 1)) ? '0 : wslot_q + 1'b1)
                                                : wslot_q;

  // Slot and column pointers; each line is one acquisition
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wslot_q   <= '0;
      col_q     <= '0;
      started_q <= 1'b0;
    end
    else if (pix_valid_i)
    begin
      started_q <= 1'b1;
      wslot_q   <= cur_slot;
      col_q     <= cur_col + 1'b1;
    end
  end

  // Fill counter saturates at SLOTS (2*MAX_DLY+1) stored acquisitions; history is full once 2d+1 are stored
  assign hist_full = fill_q > CNT_W'(2 * dly);
  always_ff @(posedge clk_i)
  begin
    if (rst_i || wr_ctrl)
    begin
      fill_q <= '0;
    end
    else if (pix_valid_i && line_start_i && fill_q != CNT_W'(SLOTS))
    begin
      fill_q <= fill_q + 1'b1;
    end
  end

  // Count of acquisitions since reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      line_cnt_q <= '0;
    end
    else if (pix_valid_i && line_start_i)
    begin
      line_cnt_q <= line_cnt_q + 1'b1;
    end
  end

  // Three memories, one per colour, all written from one exposure
  logic [PIX_W-1:0]  wr_pix [3];
  logic [PIX_W-1:0]  rd_pix [3];
  logic [ADDR_W-1:0] a_g;
  logic [ADDR_W-1:0] a_old;
  logic [ADDR_W-1:0] a_w;

  assign wr_pix[0] = pix_red_i;
  assign wr_pix[1] = pix_green_i;
  assign wr_pix[2] = pix_blue_i;
  assign a_w   = slot_addr(cur_slot, cur_col);
  assign a_g   = slot_addr(slot_back(cur_slot, dly), cur_col);
  assign a_old = slot_addr(slot_back(cur_slot, {dly[SLOT_W-1:0], 1'b0}), cur_col);

  // Index 0 red, 1 green, 2 blue; green reads d back, the other two 2d back
  for (genvar c = 0; c < 3; c++)
  begin : g_colour
    tclr_line_ram #(.WIDTH(PIX_W), .DEPTH(DEPTH)) u_line_ram (
      .clk_i   (clk_i),
      .we_i    (pix_valid_i),
      .waddr_i (a_w),
      .wdata_i (wr_pix[c]),
      .raddr_i ((c == 1) ? a_g : a_old),
      .rdata_o (rd_pix[c])
    );
  end

  //--------------------------------------------------------------
  // Output merge
  //--------------------------------------------------------------
  logic             v_q;
  logic             ls_q;
  logic [PIX_W-1:0] cr_q;
  logic [PIX_W-1:0] cg_q;
  logic [PIX_W-1:0] cb_q;
  tclr_mode_t       mode_q;

  // Align current pixel with the one-cycle memory read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      v_q    <= 1'b0;
      ls_q   <= 1'b0;
      cr_q   <= '0;
      cg_q   <= '0;
      cb_q   <= '0;
      mode_q <= TCLR_BYPASS;
    end
    else
    begin
      v_q    <= pix_valid_i;
      ls_q   <= pix_valid_i && line_start_i;
      cr_q   <= pix_red_i;
      cg_q   <= pix_green_i;
      cb_q   <= pix_blue_i;
      mode_q <= mode;
    end
  end

  // Registered output pixel
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_valid_o      <= 1'b0;
      out_line_start_o <= 1'b0;
      out_line_ok_o    <= 1'b0;
      out_red_o        <= '0;
      out_green_o      <= '0;
      out_blue_o       <= '0;
    end
    else
    begin
      out_valid_o      <= v_q;
      out_line_start_o <= ls_q;
      if (ls_q)
      begin
        out_line_ok_o <= hist_full;
      end
      unique case (mode_q)
        TCLR_BYPASS:
        begin
          out_red_o   <= cr_q;
          out_green_o <= cg_q;
          out_blue_o  <= cb_q;
        end
        TCLR_RED_FIRST:
        begin
          out_red_o   <= cr_q;
          out_green_o <= rd_pix[1];
          out_blue_o  <= rd_pix[2];
        end
        TCLR_BLUE_FIRST:
        begin
          out_red_o   <= rd_pix[0];
          out_green_o <= rd_pix[1];
          out_blue_o  <= cb_q;
        end
        default:
        begin
          out_red_o   <= cr_q;
          out_green_o <= cg_q;
          out_blue_o  <= cb_q;
        end
      endcase
    end
  end

  logic unused_ok;
  assign unused_ok = |wb_sel_i[3:1]; // Upper byte lanes carry nothing
endmodule

//--- sim/tclr_realigner_assertions.sv
// Checker for the colour line realigner ports
`timescale 1ns/1ps
module tclr_realigner_assertions
  import tclr_pkg::*;
#(
  parameter int PIX_W   = 8,
  parameter int LINE_W  = 64,
  parameter int MAX_DLY = TCLR_SET_MAX
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic line_start_i,
  input wire logic pix_valid_i,
  input wire logic out_valid_o,
  input wire logic out_line_start_o,
  input wire logic out_line_ok_o
);
  // ----------------------------------------
  // Bus and stream timing
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_on_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_pix_latency: assert property (pix_valid_i |-> ##2 out_valid_o)
    else $error("pixel not out after two cycles");
  a_out_cause: assert property (out_valid_o |-> $past(pix_valid_i, 2))
    else $error("output pixel without input pixel");
  a_start_latency: assert property (line_start_i && pix_valid_i |-> ##2 out_line_start_o)
    else $error("line start not passed on");
  a_start_cause: assert property (out_line_start_o |-> out_valid_o && $past(line_start_i, 2))
    else $error("stray output line start");
  a_ok_held: assert property ($changed(out_line_ok_o) |-> out_line_start_o)
    else $error("line valid flag moved inside a line");
  c_bus_write: cover property (wb_ack_o && wb_we_i);
  c_full_line: cover property (out_line_start_o && out_line_ok_o);
  c_history_lost: cover property ($fell(out_line_ok_o));
endmodule

bind tclr_realigner tclr_realigner_assertions #(.PIX_W(PIX_W), .LINE_W(LINE_W), .MAX_DLY(MAX_DLY)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .line_start_i(line_start_i), .pix_valid_i(pix_valid_i), .out_valid_o(out_valid_o),
  .out_line_start_o(out_line_start_o), .out_line_ok_o(out_line_ok_o));

//--- sim/tclr_sensor_model.sv
// Sensor readout model sending one line of pixels per trigger
`timescale 1ns/1ps
module tclr_sensor_model #(
  parameter int LINE_W = 4
)(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       trig_i,
  output logic            busy_o,
  output logic            line_start_o,
  output logic            pix_valid_o,
  output logic      [7:0] red_o,
  output logic      [7:0] green_o,
  output logic      [7:0] blue_o
);
  logic [7:0] acq_q;
  logic [7:0] col_q;
  logic [7:0] val;
  // Pixel value names acquisition and column
  assign val = 8'(acq_q * LINE_W + col_q);
  // Idle colour outputs toggle so stale data never looks valid
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_o <= 1'b0;
      acq_q <= 8'h00;
      col_q <= 8'h00;
      pix_valid_o <= 1'b0;
      line_start_o <= 1'b0;
      red_o <= 8'h00;
      green_o <= 8'h00;
      blue_o <= 8'h00;
    end
    else if (busy_o)
    begin
      pix_valid_o <= 1'b1;
      line_start_o <= (col_q == 8'h00);
      red_o <= val;
      green_o <= val ^ 8'h55;
      blue_o <= val ^ 8'hAA;
      col_q <= col_q + 8'h01;
      if (col_q == 8'(LINE_W - 1))
      begin
        busy_o <= 1'b0;
        acq_q <= acq_q + 8'h01;
      end
    end
    else
    begin
      pix_valid_o <= 1'b0;
      line_start_o <= 1'b0;
      red_o <= ~red_o;
      green_o <= ~green_o;
      blue_o <= ~blue_o;
      col_q <= 8'h00;
      busy_o <= trig_i;
    end
  end
endmodule

//--- sim/tclr_realigner_tb.sv
// Testbench of the colour line realigner
`timescale 1ns/1ps
module tclr_realigner_tb;
  import tclr_pkg::*;
  localparam int LW = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic trig = 1'b0;
  logic [31:0] rdat;
  logic ack, busy, ls, pv, ov, ols, ook;
  logic [7:0] r, gr, b, orr, og, ob;
  logic [31:0] v;
  int checked = 0, miscompares = 0, sent = 0, base = 0, m_v = 0;
  int g = 0, col = 0, a, k, d;
  // ----------------------------------------
  // Design, sensor model and clock
  // ----------------------------------------
  tclr_realigner #(.PIX_W(8), .LINE_W(LW), .MAX_DLY(15)) u_tclr_realigner (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .line_start_i(ls), .pix_valid_i(pv), .pix_red_i(r), .pix_green_i(gr),
    .pix_blue_i(b), .out_valid_o(ov), .out_line_start_o(ols), .out_line_ok_o(ook), .out_red_o(orr),
    .out_green_o(og), .out_blue_o(ob));
  tclr_sensor_model #(.LINE_W(LW)) u_tclr_sensor_model (.clk_i(clk_i), .rst_i(rst_i), .trig_i(trig),
    .busy_o(busy), .line_start_o(ls), .pix_valid_o(pv), .red_o(r), .green_o(gr), .blue_o(b));
  initial forever #2.5 clk_i = ~clk_i;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] pix(int acq, int c);
    return 8'(acq * LW + c);
  endfunction
  // Classic cycle held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] dat, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= dat;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic set_mode(int s);
    wb(1'b1, TCLR_ADDR_CTRL, 32'(s), v);
    base = sent;
    m_v = s;
  endtask
  task automatic send(int n);
    repeat (n)
    begin
      @(posedge clk_i);
      trig <= 1'b1;
      @(posedge clk_i);
      trig <= 1'b0;
      do @(posedge clk_i); while (busy === 1'b1);
      sent++;
    end
  endtask
  // Output monitor: merge sources follow mode and history
  always @(posedge clk_i)
  begin
    if (ov === 1'b1)
    begin
      if (ols === 1'b1)
      begin
        g++;
        col = 0;
      end
      else col++;
      a = g - 1;
      k = a - base;
      d = (m_v < 0) ? -m_v : m_v;
      if (ols === 1'b1 && (m_v != 0 || k >= 1)) check("line_ok", ook, (m_v == 0 || k >= 2 * d));
      if (m_v == 0 || k >= 2 * d)
      begin
        check("red", orr, pix(m_v < 0 ? a - 2 * d : a, col));
        check("green", og, pix(a - d, col) ^ 8'h55);
        check("blue", ob, pix(m_v > 0 ? a - 2 * d : a, col) ^ 8'hAA);
      end
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    wb(1'b0, TCLR_ADDR_CTRL, 32'h0, v);
    check("ctrl_reset", v, 32'h0);
    wb(1'b0, TCLR_ADDR_STATUS, 32'h0, v);
    check("bypass_flag", v[TCLR_ST_BYPASS], 1'b1);
  endtask
  task automatic t_bypass();
    send(3);
  endtask
  task automatic t_red();
    set_mode(15);
    send(32);
    wb(1'b0, TCLR_ADDR_STATUS, 32'h0, v);
    check("status_red", v[2:0], 3'h1);
    wb(1'b0, TCLR_ADDR_COUNT, 32'h0, v);
    check("count", v[15:0], 16'(sent));
  endtask
  task automatic t_blue();
    set_mode(-2);
    send(6);
    wb(1'b0, TCLR_ADDR_STATUS, 32'h0, v);
    check("status_blue", v[2:0], 3'h3);
    check("out_lines", 32'(g), 32'(sent));
  endtask
  // Out of range values leave the setting alone
  task automatic t_range();
    logic [7:0] bad [2] = '{8'h10, 8'hF0};
    foreach (bad[i])
    begin
      wb(1'b1, TCLR_ADDR_CTRL, {24'h0, bad[i]}, v);
      wb(1'b0, TCLR_ADDR_CTRL, 32'h0, v);
      check("ctrl_kept", v, 32'hFFFFFFFE);
      wb(1'b0, TCLR_ADDR_STATUS, 32'h0, v);
      check("range_flag", v[TCLR_ST_RANGE], 1'b1);
    end
    set_mode(-15);
    wb(1'b0, TCLR_ADDR_CTRL, 32'h0, v);
    check("ctrl_min", v, 32'hFFFFFFF1);
  endtask
  task automatic t_unmapped();
    wb(1'b1, 4'hC, 32'h5, v);
    wb(1'b0, 4'hC, 32'h0, v);
    check("unmapped", v, 32'h0);
    wb(1'b0, TCLR_ADDR_CTRL, 32'h0, v);
    check("ctrl_after", v, 32'hFFFFFFF1);
  endtask
  task automatic give_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Run takes well under 2000 cycles; the limit is ten times that
  initial
  begin
    #100000;
    miscompares++;
    give_verdict();
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_bypass();
    t_red();
    t_blue();
    t_range();
    t_unmapped();
    give_verdict();
  end
endmodule
